// file: verilog/cfr_pkg.sv
// Shared constants, op codes and decode helpers for the flag and pointer block
package cfr_pkg;

  // System register addresses in the register file
  localparam logic [7:0] ADDR_FLAGS = 8'he7;
  localparam logic [7:0] ADDR_PTR0  = 8'he8;
  localparam logic [7:0] ADDR_PTR1  = 8'he9;
  localparam logic [7:0] ADDR_PAGE  = 8'hea;

  // Flag bit positions
  localparam int FLG_C  = 7;
  localparam int FLG_Z  = 6;
  localparam int FLG_S  = 5;
  localparam int FLG_V  = 4;
  localparam int FLG_DA = 3;
  localparam int FLG_H  = 2;
  localparam int FLG_R  = 1;
  localparam int FLG_DP = 0;

  // Reset values and writable masks
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] FLAGS_WMASK = 8'hfd;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;

  // Pointer and page field layout
  localparam int PTR_BLK_LSB = 3;
  localparam int PTR_TWIN    = 2;
  localparam int PAGE_LSB    = 2;
  localparam int BLK_W       = 5;
  localparam int PAGE_W      = 6;
  localparam int NUM_PAGES   = 64;

  // Register file groups
  localparam logic [3:0] GROUP_D = 4'hd;
  localparam logic [3:0] GROUP_F = 4'hf;

  // BCD correction constants
  localparam logic [7:0] BCD_LO_FIX = 8'h06;
  localparam logic [7:0] BCD_HI_FIX = 8'h60;
  localparam logic [7:0] BCD_MAX    = 8'h99;
  localparam logic [3:0] BCD_DIGIT  = 4'h9;

  // Operations reported by the execute unit
  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_CMP, OP_SHIFT, OP_SWAP, OP_ROT,
    OP_DAFIX, OP_MULDIV, OP_LOGIC, OP_INCDEC, OP_TEST,
    OP_SCF, OP_RCF, OP_CCF, OP_SDM, OP_SPM,
    OP_SRP, OP_SET_WINDOW_A, OP_SET_WINDOW_B, OP_SPP
  } cfr_op_e;

  // Decode of the four system registers held here
  function automatic logic cfr_is_local(input logic [7:0] a);
    cfr_is_local = (a == ADDR_FLAGS) || (a == ADDR_PTR0) ||
                   (a == ADDR_PTR1) || (a == ADDR_PAGE);
  endfunction : cfr_is_local

endpackage : cfr_pkg

// file: verilog/cfr_flag_calc.sv
// Next flag value and decimal adjust from one execute-unit operation
`timescale 1ns/1ps
`default_nettype none
module cfr_flag_calc
  import cfr_pkg::*;
(
  input  wire cfr_pkg::cfr_op_e op,
  input  wire logic             word,
  input  wire logic [15:0]      result,
  input  wire logic             carry,
  input  wire logic             half,
  input  wire logic             ovf,
  input  wire logic [7:0]       cur,
  output logic [7:0]            next_flags,
  output logic                  upd,
  output logic [7:0]            da_byte
);

  logic       c_op;
  logic       zsv_op;
  logic       da_c;
  logic       sub;
  logic [7:0] acc;
  logic [15:0] res;

  // Decimal adjust from the previous add/sub kind and nibble carry
  always_comb
  begin
    acc = result[7:0];
    sub = cur[FLG_DA];
    da_c = cur[FLG_C];
    da_byte = acc;
    if (!sub)
    begin
      if (cur[FLG_C] || acc > BCD_MAX)
      begin
        da_c = 1'b1;
      end
      if (cur[FLG_H] || acc[3:0] > BCD_DIGIT)
      begin
        da_byte = da_byte + BCD_LO_FIX;
      end
      if (da_c)
      begin
        da_byte = da_byte + BCD_HI_FIX;
      end
    end
    else
    begin
      if (cur[FLG_H])
      begin
        da_byte = da_byte - BCD_LO_FIX;
      end
      if (cur[FLG_C])
      begin
        da_byte = da_byte - BCD_HI_FIX;
      end
    end
  end

  // Which flags an operation touches
  always_comb
  begin
    c_op = op inside {OP_ADD, OP_SUB, OP_CMP, OP_SHIFT, OP_SWAP,
                      OP_ROT, OP_DAFIX, OP_MULDIV};
    zsv_op = c_op || (op inside {OP_LOGIC, OP_INCDEC, OP_TEST});
    upd = zsv_op || (op inside {OP_SCF, OP_RCF, OP_CCF, OP_SDM, OP_SPM});
  end

  // Flag values; zero and sign come from the accumulator result
  always_comb
  begin
    res = (op == OP_DAFIX) ? {8'h00, da_byte} : result;
    next_flags = cur;
    if (c_op)
    begin
      next_flags[FLG_C] = (op == OP_DAFIX) ? da_c : carry;
    end
    if (zsv_op)
    begin
      next_flags[FLG_Z] = word ? (res == 16'h0000) : (res[7:0] == 8'h00);
      next_flags[FLG_S] = word ? res[15] : res[7];
      next_flags[FLG_V] = ovf;
    end
    if ((op == OP_ADD || op == OP_SUB) && !word)
    begin
      next_flags[FLG_DA] = (op == OP_SUB);
      next_flags[FLG_H] = half;
    end
    unique case (op)
      OP_SCF: next_flags[FLG_C] = 1'b1;
      OP_RCF: next_flags[FLG_C] = 1'b0;
      OP_CCF: next_flags[FLG_C] = ~cur[FLG_C];
      OP_SDM: next_flags[FLG_DP] = 1'b1;
      OP_SPM: next_flags[FLG_DP] = 1'b0;
      default: ;
    endcase
    next_flags[FLG_R] = 1'b0;
  end

endmodule : cfr_flag_calc
`default_nettype wire

// file: verilog/cfr_reg_map.sv
// Working-register and paged-group address translation
`timescale 1ns/1ps
`default_nettype none
module cfr_reg_map
  import cfr_pkg::*;
#(
  parameter logic [63:0] PAGE_PRESENT = 64'hffffffffffffffff
)
(
  input  wire logic       wreg,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] ptr_low,
  input  wire logic [7:0] ptr_high,
  input  wire logic [7:0] page_sel,
  output logic [7:0]      phys,
  output logic            err
);

  logic [BLK_W-1:0]  blk;
  logic [PAGE_W-1:0] page;

  // Name to block; single mode drops the odd block bit
  always_comb
  begin
    page = page_sel[7:PAGE_LSB];
    blk = addr[3] ? ptr_high[7:PTR_BLK_LSB] : ptr_low[7:PTR_BLK_LSB];
    if (!wreg)
    begin
      phys = addr;
    end
    else if (ptr_low[PTR_TWIN])
    begin
      phys = {blk, addr[2:0]};
    end
    else
    begin
      phys = {ptr_low[7:4], addr[3:0]};
    end
    // Group D only through pointers; absent pages do not exist
    err = (!wreg && addr[7:4] == GROUP_D) ||
          (phys[7:4] == GROUP_F && !PAGE_PRESENT[page]);
  end

endmodule : cfr_reg_map
`default_nettype wire

// file: verilog/cfr_core.sv
// CPU flag register, working-register pointers and page selector
//
// Functional notes
// - Flag register clears at reset; C Z S V DA H reserved DP from bit 7 down.
// - Carry takes carry out of bit 7 for bytes or bit 15 for words.
// - Set, clear and invert carry operations force or toggle the carry.
// - Carry and zero/sign/overflow are each updated by their listed operation classes.
// - Zero flag set when the accumulator result is zero, else cleared.
// - Sign flag copies bit 7 or bit 15 of the result.
// - Overflow flag shows signed two's-complement range error.
// - DA flag records add versus subtract for the following decimal fix.
// - Half carry captures bit 3 carry or borrow; decimal fix consumes it.
// - Data-space ops set or clear DP; set means data pages used.
// - Register file is 32 blocks of 8, indexed by 5 bits.
// - Twin-window ops set the twin bit in both pointers; single clears it.
// - Single window starts at the requested block rounded down to even.
// - Twin mode maps r0-r7 via low pointer, r8-r15 via high.
// - Low pointer holds block in 7:3, twin bit 2, zeros below.
// - High pointer holds its block in 7:3, twin bit copy in 2, zeros below.
// - Group D not reachable by explicit register addressing.
// - Page selector picks one of 64 pages and persists until rewritten.
// - A page exists only when its peripheral is present.
// - Interrupt entry pushes flags; interrupt return restores them.
// - Page selector holds page 0-63 in bits 7:2, zeros below.
`timescale 1ns/1ps
`default_nettype none
module cfr_core
  import cfr_pkg::*;
#(
  parameter logic [63:0] PAGE_PRESENT = 64'hffffffffffffffff
)
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Execute unit operation report
  input  wire logic             op_valid,
  input  wire cfr_pkg::cfr_op_e op_code,
  input  wire logic             op_word,
  input  wire logic [15:0]      alu_result,
  input  wire logic             alu_carry,
  input  wire logic             alu_half,
  input  wire logic             alu_ovf,
  input  wire logic [4:0]       op_block,
  input  wire logic [5:0]       op_page,
  // Register file access to the system registers held here
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wr_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_rd_addr,
  output logic [7:0]            reg_rdata,
  output logic                  reg_rd_hit,
  // Operand address translation
  input  wire logic             map_req,
  input  wire logic             map_wreg,
  input  wire logic [7:0]       map_addr,
  output logic                  map_vld,
  output logic [7:0]            map_phys,
  output logic                  map_err,
  output logic [5:0]            map_page,
  // Interrupt stacking of the flags
  input  wire logic             irq_entry,
  input  wire logic             irq_return,
  input  wire logic [7:0]       stack_rdata,
  output logic                  stack_push,
  output logic [7:0]            stack_wdata,
  // State seen by the execute unit
  output logic [7:0]            flags,
  output logic [7:0]            ptr_low,
  output logic [7:0]            ptr_high,
  output logic [7:0]            page_sel,
  output logic                  data_uses_dpr,
  output logic [7:0]            da_result,
  output logic                  da_valid
);

  logic [7:0] next_flags;
  logic       flag_upd;
  logic [7:0] da_byte;
  logic [7:0] next_phys;
  logic       next_err;
  logic       op_take;
  logic       wr_flags;
  logic       wr_ptr0;
  logic       wr_ptr1;
  logic       wr_page;

  // Write decode from the register file port
  always_comb
  begin
    wr_flags = reg_wr && (reg_wr_addr == ADDR_FLAGS);
    wr_ptr0 = reg_wr && (reg_wr_addr == ADDR_PTR0);
    wr_ptr1 = reg_wr && (reg_wr_addr == ADDR_PTR1);
    wr_page = reg_wr && (reg_wr_addr == ADDR_PAGE);
    op_take = op_valid && !irq_entry && !irq_return;
  end

  // Flag arithmetic is kept apart so the execute unit can share it
  cfr_flag_calc u_calc (
    .op         (op_code),
    .word       (op_word),
    .result     (alu_result),
    .carry      (alu_carry),
    .half       (alu_half),
    .ovf        (alu_ovf),
    .cur        (flags),
    .next_flags (next_flags),
    .upd        (flag_upd),
    .da_byte    (da_byte)
  );

  // Translation reads the live pointers, so the last op is honoured
  cfr_reg_map #(
    .PAGE_PRESENT (PAGE_PRESENT)
  ) u_map (
    .wreg     (map_wreg),
    .addr     (map_addr),
    .ptr_low  (ptr_low),
    .ptr_high (ptr_high),
    .page_sel (page_sel),
    .phys     (next_phys),
    .err      (next_err)
  );

  // Flag register; stack restore beats an op, an op beats a bus write
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      flags <= FLAGS_RST;
    end
    else if (irq_return)
    begin
      flags <= stack_rdata & FLAGS_WMASK;
    end
    else if (op_take && flag_upd)
    begin
      flags <= next_flags;
    end
    else if (wr_flags)
    begin
      // Reserved bit is masked even if software gets it wrong
      flags <= reg_wdata & FLAGS_WMASK;
    end
  end

  // Data accesses go through the data pages only when DP is set
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      data_uses_dpr <= FLAGS_RST[FLG_DP];
    end
    else if (irq_return)
    begin
      data_uses_dpr <= stack_rdata[FLG_DP];
    end
    else if (op_take && flag_upd)
    begin
      data_uses_dpr <= next_flags[FLG_DP];
    end
    else if (wr_flags)
    begin
      data_uses_dpr <= reg_wdata[FLG_DP];
    end
  end

  // Low pointer: block field and twin bit; low two bits stay zero
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ptr_low <= PTR_RST;
    end
    else if (op_take && op_code == OP_SRP)
    begin
      ptr_low <= {op_block, 1'b0, 2'b00};
    end
    else if (op_take && op_code == OP_SET_WINDOW_A)
    begin
      ptr_low <= {op_block, 1'b1, 2'b00};
    end
    else if (op_take && op_code == OP_SET_WINDOW_B)
    begin
      ptr_low[PTR_TWIN] <= 1'b1;
    end
    else if (wr_ptr0)
    begin
      ptr_low <= {reg_wdata[7:PTR_BLK_LSB], reg_wdata[PTR_TWIN], 2'b00};
    end
    else if (wr_ptr1)
    begin
      // Twin bit is one mode, mirrored in both pointers
      ptr_low[PTR_TWIN] <= reg_wdata[PTR_TWIN];
    end
  end

  // High pointer: block for r8-r15 plus a copy of the twin bit
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ptr_high <= PTR_RST;
    end
    else if (op_take && op_code == OP_SET_WINDOW_B)
    begin
      ptr_high <= {op_block, 1'b1, 2'b00};
    end
    else if (op_take && op_code == OP_SET_WINDOW_A)
    begin
      ptr_high[PTR_TWIN] <= 1'b1;
    end
    else if (op_take && op_code == OP_SRP)
    begin
      ptr_high[PTR_TWIN] <= 1'b0;
    end
    else if (wr_ptr1)
    begin
      ptr_high <= {reg_wdata[7:PTR_BLK_LSB], reg_wdata[PTR_TWIN], 2'b00};
    end
    else if (wr_ptr0)
    begin
      ptr_high[PTR_TWIN] <= reg_wdata[PTR_TWIN];
    end
  end

  // Page selector is not stacked on interrupt entry
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      page_sel <= PAGE_RST;
    end
    else if (op_take && op_code == OP_SPP)
    begin
      page_sel <= {op_page, 2'b00};
    end
    else if (wr_page)
    begin
      page_sel <= {reg_wdata[7:PAGE_LSB], 2'b00};
    end
  end

  // Register read port, one cycle after the request
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      reg_rdata <= 8'h00;
      reg_rd_hit <= 1'b0;
    end
    else
    begin
      reg_rd_hit <= reg_rd && cfr_is_local(reg_rd_addr);
      if (!reg_rd)
      begin
        reg_rdata <= 8'h00;
      end
      else
      begin
        unique case (reg_rd_addr)
          ADDR_FLAGS: reg_rdata <= flags;
          ADDR_PTR0:  reg_rdata <= ptr_low;
          ADDR_PTR1:  reg_rdata <= ptr_high;
          ADDR_PAGE:  reg_rdata <= page_sel;
          default:    reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Registered translation result
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      map_vld <= 1'b0;
      map_phys <= 8'h00;
      map_err <= 1'b0;
      map_page <= 6'h00;
    end
    else
    begin
      map_vld <= map_req;
      if (map_req)
      begin
        map_phys <= next_phys;
        map_err <= next_err;
        map_page <= page_sel[7:PAGE_LSB];
      end
    end
  end

  // Flags go out to the system stack on interrupt entry
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      stack_push <= 1'b0;
      stack_wdata <= 8'h00;
    end
    else
    begin
      stack_push <= irq_entry;
      if (irq_entry)
      begin
        stack_wdata <= flags;
      end
    end
  end

  // Decimal fix result handed back to the execute unit
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      da_result <= 8'h00;
      da_valid <= 1'b0;
    end
    else
    begin
      da_valid <= op_take && op_code == OP_DAFIX;
      if (op_take && op_code == OP_DAFIX)
      begin
        da_result <= da_byte;
      end
    end
  end

endmodule : cfr_core
`default_nettype wire

// file: sim/cfr_core_monitor.sv
// Checker on the ports of the flag, pointer and page core
`timescale 1ns/1ps
`default_nettype none
module cfr_core_monitor
  import cfr_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             op_valid,
  input  wire cfr_pkg::cfr_op_e op_code,
  input  wire logic [5:0]       op_page,
  input  wire logic             map_req,
  input  wire logic             map_wreg,
  input  wire logic [7:0]       map_addr,
  input  wire logic             map_vld,
  input  wire logic [7:0]       map_phys,
  input  wire logic             map_err,
  input  wire logic             irq_entry,
  input  wire logic             irq_return,
  input  wire logic [7:0]       stack_rdata,
  input  wire logic             stack_push,
  input  wire logic [7:0]       stack_wdata,
  input  wire logic [7:0]       flags,
  input  wire logic [7:0]       ptr_low,
  input  wire logic [7:0]       ptr_high,
  input  wire logic [7:0]       page_sel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic op_ok;
  // Ops sharing a cycle with an interrupt edge are dropped, so exclude them
  assign op_ok = op_valid && !irq_entry && !irq_return;
  // Steps of the operations watched below
  sequence s_scf; op_ok && op_code == OP_SCF; endsequence
  sequence s_ccf; op_ok && op_code == OP_CCF; endsequence
  sequence s_spp; op_ok && op_code == OP_SPP; endsequence
  sequence s_push; stack_push && stack_wdata == $past(flags); endsequence
  property p_rsv; flags[FLG_R] == 1'b0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag bit set");
  property p_low2; {ptr_low[1:0], ptr_high[1:0], page_sel[1:0]} == 6'h00; endproperty
  a_low2: assert property (p_low2) else $error("low pointer bits set");
  property p_twin; ptr_low[PTR_TWIN] == ptr_high[PTR_TWIN]; endproperty
  a_twin: assert property (p_twin) else $error("twin bits differ");
  property p_scf; s_scf |=> flags[FLG_C]; endproperty
  a_scf: assert property (p_scf) else $error("carry not set");
  property p_ccf; s_ccf |=> flags[FLG_C] != $past(flags[FLG_C]); endproperty
  a_ccf: assert property (p_ccf) else $error("carry not inverted");
  property p_spp; s_spp |=> page_sel[7:2] == $past(op_page); endproperty
  a_spp: assert property (p_spp) else $error("page not loaded");
  property p_push; irq_entry |=> s_push; endproperty
  a_push: assert property (p_push) else $error("flags not stacked");
  property p_ret; irq_return |=> flags == ($past(stack_rdata) & 8'hfd); endproperty
  a_ret: assert property (p_ret) else $error("flags not restored");
  property p_grpd; map_req && !map_wreg && map_addr[7:4] == GROUP_D |=> map_vld && map_err;
  endproperty
  a_grpd: assert property (p_grpd) else $error("group d reached");
  property p_single;
    map_req && map_wreg && !ptr_low[PTR_TWIN]
      |=> map_phys == {$past(ptr_low[7:4]), $past(map_addr[3:0])};
  endproperty
  a_single: assert property (p_single) else $error("single window wrong");
  property p_hi;
    map_req && map_wreg && ptr_low[PTR_TWIN] && map_addr[3]
      |=> map_phys[7:3] == $past(ptr_high[7:3]);
  endproperty
  a_hi: assert property (p_hi) else $error("upper window wrong");
endmodule : cfr_core_monitor
bind cfr_core cfr_core_monitor cfr_core_monitor_i (.ref_clk, .rstn, .op_valid, .op_code,
  .op_page, .map_req, .map_wreg, .map_addr, .map_vld, .map_phys, .map_err, .irq_entry,
  .irq_return, .stack_rdata, .stack_push, .stack_wdata, .flags, .ptr_low, .ptr_high,
  .page_sel);
`default_nettype wire

// file: sim/cfr_exec_model.sv
// Execute-unit model reporting operations to the core
`timescale 1ns/1ps
`default_nettype none
module cfr_exec_model
  import cfr_pkg::*;
(
  input  wire logic        ref_clk,
  output var logic         op_valid,
  output cfr_pkg::cfr_op_e op_code,
  output var logic         op_word,
  output var logic [15:0]  alu_result,
  output var logic         alu_carry,
  output var logic         alu_half,
  output var logic         alu_ovf,
  output var logic [4:0]   op_block,
  output var logic [5:0]   op_page
);
  // Idle until the first report
  initial
  begin
    op_valid = 1'b0;
    op_code = OP_NONE;
    {op_word, alu_result, alu_carry, alu_half, alu_ovf, op_block, op_page} = '0;
  end
  // One report per call; the result is scrambled after so stale data never matches
  task automatic issue(input cfr_op_e c, input logic w, input logic [15:0] r,
                       input logic [2:0] chv, input logic [4:0] b, input logic [5:0] p);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = c;
    op_word = w;
    alu_result = r;
    {alu_carry, alu_half, alu_ovf} = chv;
    op_block = b;
    op_page = p;
    @(negedge ref_clk);
    op_valid = 1'b0;
    alu_result = ~r;
  endtask : issue
endmodule : cfr_exec_model
`default_nettype wire

// file: sim/cfr_core_bench.sv
// Self-checking bench for the flag, pointer and page core
`timescale 1ns/1ps
`default_nettype none
module cfr_core_bench;
  import cfr_pkg::*;
  localparam logic [63:0] PP = 64'hf0f0_ffff_0000_ff0f;
  logic        ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        map_req = 1'b0, map_wreg = 1'b0, irq_entry = 1'b0, irq_return = 1'b0;
  logic [7:0]  reg_wr_addr = 8'h00, reg_wdata = 8'h00, reg_rd_addr = 8'h00;
  logic [7:0]  map_addr = 8'h00, stack_rdata = 8'h00;
  logic [7:0]  reg_rdata, map_phys, stack_wdata, flags, ptr_low, ptr_high, page_sel;
  logic [7:0]  da_result;
  logic        reg_rd_hit, map_vld, map_err, stack_push, data_uses_dpr, da_valid;
  logic        op_valid, op_word, alu_carry, alu_half, alu_ovf;
  logic [5:0]  map_page, op_page, pg;
  logic [4:0]  op_block, blk;
  logic [15:0] alu_result;
  cfr_op_e     op_code;
  logic [7:0]  mf = 8'h00, mp0 = 8'h00, mp1 = 8'h00, mpg = 8'h00;
  int          fails = 0, check_count = 0, cyc = 0, a, b, k, d;
  cfr_op_e     cq[$] = '{OP_SDM, OP_SCF, OP_CCF, OP_RCF, OP_CCF, OP_SPM, OP_SDM};
  cfr_op_e     aq[$] = '{OP_ADD, OP_SUB, OP_CMP, OP_SHIFT, OP_SWAP, OP_ROT, OP_MULDIV,
                         OP_LOGIC, OP_INCDEC, OP_TEST};
  cfr_op_e     pq[$] = '{OP_SRP, OP_SET_WINDOW_A, OP_SET_WINDOW_B, OP_SPP};

  cfr_core #(.PAGE_PRESENT(PP)) cfr_core_i (.ref_clk, .rstn, .op_valid, .op_code, .op_word,
    .alu_result, .alu_carry, .alu_half, .alu_ovf, .op_block, .op_page, .reg_wr, .reg_wr_addr,
    .reg_wdata, .reg_rd, .reg_rd_addr, .reg_rdata, .reg_rd_hit, .map_req, .map_wreg,
    .map_addr, .map_vld, .map_phys, .map_err, .map_page, .irq_entry, .irq_return,
    .stack_rdata, .stack_push, .stack_wdata, .flags, .ptr_low, .ptr_high, .page_sel,
    .data_uses_dpr, .da_result, .da_valid);
  cfr_exec_model cfr_exec_model_i (.ref_clk, .op_valid, .op_code, .op_word, .alu_result,
    .alu_carry, .alu_half, .alu_ovf, .op_block, .op_page);

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  task automatic end_of_test;
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_of_test;
    end
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic st;
    chk("flags", flags, mf);
    chk("ptr_low", ptr_low, mp0);
    chk("ptr_high", ptr_high, mp1);
    chk("page_sel", page_sel, mpg);
  endtask : st

  // Flag model; for non-adder ops the result is a plus b
  task automatic alu(input cfr_op_e c, input logic w, input int a, input int b,
                     input int cin, input int vin);
    int r, cy, h, v, sb;
    sb = w ? 15 : 7;
    a &= (2 << sb) - 1;
    b &= (2 << sb) - 1;
    r = (c == OP_SUB) ? a - b : a + b;
    cy = (c inside {OP_ADD, OP_SUB}) ? (r >> (sb + 1)) & 1 : cin;
    h = (((c == OP_SUB) ? (a & 15) - (b & 15) : (a & 15) + (b & 15)) >> 4) & 1;
    r &= (2 << sb) - 1;
    v = (c == OP_ADD) ? ((~(a ^ b) & (a ^ r)) >> sb) & 1 :
        (c == OP_SUB) ? (((a ^ b) & (a ^ r)) >> sb) & 1 : vin;
    cfr_exec_model_i.issue(c, w, r[15:0], {cy[0], h[0], v[0]}, 5'h00, 6'h00);
    if (c inside {OP_ADD, OP_SUB, OP_CMP, OP_SHIFT, OP_SWAP, OP_ROT, OP_MULDIV})
      mf[7] = cy[0];
    mf[6:4] = {r == 0, r[sb], v[0]};
    if (!w && c inside {OP_ADD, OP_SUB})
      mf[3:2] = {c == OP_SUB, h[0]};
    st;
  endtask : alu

  // Decimal fix model driven by the stored kind, half carry and carry
  task automatic dafix(input int x);
    int y;
    logic cy;
    cy = mf[7] | (!mf[3] && x > 'h99);
    y = x;
    if (!mf[3])
      y += ((mf[2] || (x & 15) > 9) ? 6 : 0) + (cy ? 'h60 : 0);
    else
      y -= (mf[2] ? 6 : 0) + (mf[7] ? 'h60 : 0);
    y &= 'hff;
    cfr_exec_model_i.issue(OP_DAFIX, 1'b0, x[15:0], 3'b000, 5'h00, 6'h00);
    mf[7:4] = {cy, y == 0, y[7], 1'b0};
    st;
    // Result strobe stands for the cycle after the op edge
    chk("da_valid", 8'(da_valid), 8'h01);
    chk("da_result", da_result, y[7:0]);
  endtask : dafix

  // Map request launched at the current falling edge, straight after an op
  task automatic map(input logic w, input logic [7:0] a);
    logic [7:0] e;
    e = !w ? a : mp0[2] ? {a[3] ? mp1[7:3] : mp0[7:3], a[2:0]} : {mp0[7:4], a[3:0]};
    map_req = 1'b1;
    map_wreg = w;
    map_addr = a;
    @(negedge ref_clk);
    map_req = 1'b0;
    map_addr = ~a;
    chk("map_vld", 8'(map_vld), 8'h01);
    chk("map_phys", map_phys, e);
    chk("map_err", 8'(map_err), 8'((!w && a[7:4] == 4'hd) ||
                                    (e[7:4] == 4'hf && !PP[mpg[7:2]])));
    chk("map_page", 8'(map_page), 8'(mpg[7:2]));
  endtask : map

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_wr_addr = a;
    reg_wdata = v;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
    case (a)
      8'he7: mf = v & 8'hfd;
      8'he8: {mp0, mp1[2]} = {v[7:2], 2'b00, v[2]};
      8'he9: {mp1, mp0[2]} = {v[7:2], 2'b00, v[2]};
      8'hea: mpg = {v[7:2], 2'b00};
      default: ;
    endcase
    st;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_rd_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk("reg_rdata", reg_rdata, e);
    chk("reg_rd_hit", 8'(reg_rd_hit), 8'(h));
  endtask : rd

  // Main sequence
  initial
  begin
    void'($urandom(22));
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    st;
    foreach (cq[i])
    begin
      cfr_exec_model_i.issue(cq[i], 1'b0, 16'h0000, 3'b000, 5'h00, 6'h00);
      mf[7] = cq[i] == OP_SCF ? 1'b1 : cq[i] == OP_RCF ? 1'b0 : cq[i] == OP_CCF ? !mf[7] : mf[7];
      mf[0] = cq[i] == OP_SDM ? 1'b1 : cq[i] == OP_SPM ? 1'b0 : mf[0];
      st;
      @(negedge ref_clk);
      chk("data_uses_dpr", 8'(data_uses_dpr), 8'(mf[0]));
    end
    alu(OP_ADD, 1'b0, 'h80, 'h80, 0, 0);
    alu(OP_ADD, 1'b1, 'hffff, 1, 0, 0);
    repeat (3)
      foreach (aq[i])
        alu(aq[i], 1'($urandom), $urandom, $urandom, $urandom_range(0, 1), $urandom_range(0, 1));
    repeat (6)
    begin
      a = $urandom_range(1, 9) * 16 + $urandom_range(0, 9);
      b = $urandom_range(0, 9) * 16 + $urandom_range(0, 9);
      k = $urandom_range(0, 1);
      alu(k ? OP_SUB : OP_ADD, 1'b0, a, b, 0, 0);
      dafix((k ? a - b : a + b) & 'hff);
    end
    repeat (48)
    begin
      k = $urandom_range(0, 3);
      blk = 5'($urandom);
      pg = 6'($urandom);
      cfr_exec_model_i.issue(pq[k], 1'b0, 16'h0000, 3'b000, blk, pg);
      case (k)
        0: {mp0, mp1[2]} = {blk, 4'b0000};
        1: {mp0, mp1[2]} = {blk, 4'b1001};
        2: {mp1, mp0[2]} = {blk, 4'b1001};
        default: mpg = {pg, 2'b00};
      endcase
      st;
      map(1'($urandom), {4'($urandom_range(12, 15)), 4'($urandom)});
    end
    for (d = 'he6; d <= 'heb; d++)
    begin
      // Software keeps the reserved flag bit clear; pointer bits stay random
      wr(8'(d), 8'($urandom) & (d == 'he7 ? 8'hfd : 8'hff));
      rd(8'he7, mf, 1'b1);
      rd(8'he8, mp0, 1'b1);
      rd(8'he9, mp1, 1'b1);
      rd(8'hea, mpg, 1'b1);
      rd(8'heb, 8'h00, 1'b0);
    end
    repeat (3)
    begin
      fork
        cfr_exec_model_i.issue(OP_CCF, 1'b0, 16'h0000, 3'b000, 5'h00, 6'h00);
        begin
          @(negedge ref_clk);
          irq_entry = 1'b1;
          @(negedge ref_clk);
          irq_entry = 1'b0;
        end
      join
      chk("stack_push", 8'(stack_push), 8'h01);
      chk("stack_wdata", stack_wdata, mf);
      // Handler leaves the page alone, so no save of the selector is needed
      st;
      d = $urandom;
      @(negedge ref_clk);
      irq_return = 1'b1;
      stack_rdata = 8'(d);
      @(negedge ref_clk);
      irq_return = 1'b0;
      stack_rdata = ~8'(d);
      mf = 8'(d) & 8'hfd;
      st;
    end
    end_of_test;
  end
endmodule : cfr_core_bench
`default_nettype wire
